// File: bench/link_remote_model.sv
// Behavioural far end of the serial link: answers the greeting with credit
`timescale 1ns/100ps
`default_nettype none
module link_remote_model (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic greeting, // Greeting token from the bank
  input wire logic slow, // Answer late when high
  input wire logic err_cmd, // Bench asks for a receive error
  output logic credit_issued, // Credit given to the far end
  output logic credit_held, // Credit held to transmit
  output logic rx_error // Receive error pulse
);
  int wait_ff;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {credit_issued, credit_held, rx_error} <= 3'h0;
      wait_ff <= 0;
    end else begin
      rx_error <= err_cmd;
      if (greeting) begin
        // Credit is withdrawn at once so a stale status cannot pass for an answer
        {credit_issued, credit_held} <= 2'h0;
        wait_ff <= slow ? 40 : 2;
      end else if (wait_ff > 1) begin
        wait_ff <= wait_ff - 1;
      end else if (wait_ff == 1) begin
        {credit_issued, credit_held} <= 2'h3;
        wait_ff <= 0;
      end
    end
  end
endmodule : link_remote_model
`default_nettype wire

// File: bench/tb_analog_node_reset_link_config.sv
// Self-checking bench of the node reset, mode and link register bank
`timescale 1ns/100ps
`default_nettype none
module tb_analog_node_reset_link_config;
  import anrl_pkg::*;
  logic ref_clk = 0, rst = 1, rst_pin_n = 1, brownout_pin = 0, osc_clk_pin = 0;
  logic wdog_expired = 0, sleep_done = 0, clk_src_change = 0, err_cmd = 0, slow = 0;
  logic rx_error, credit_issued, credit_held, sys_rst_o, tile_rst_o, mode_pins_oe;
  logic us_tick, ms_tick;
  logic [1:0] mode_pins;
  logic [15:0] node_id;
  logic [31:0] v;
  logic [6:0] ef;
  logic [15:0] idv;
  logic [6:0] fv [7] = '{7'h04, 7'h05, 7'h65, 7'h64, 7'h00, 7'h7f, 7'h05};
  cfg_req_t req = '0;
  cfg_rsp_t rsp;
  link_ctl_t link_ctl;
  logic [32:0] expq [$];
  int fail_count = 0;
  int samples_checked = 0;
  int n;
  analog_node_reset_link_config #(.SYS_RST_OSC_CYCLES(16)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .req(req), .rsp(rsp), .rst_pin_n(rst_pin_n),
    .brownout_pin(brownout_pin), .osc_clk_pin(osc_clk_pin), .wdog_expired(wdog_expired),
    .sleep_done(sleep_done), .clk_src_change(clk_src_change), .rx_error(rx_error),
    .credit_issued(credit_issued), .credit_held(credit_held), .sys_rst_o(sys_rst_o),
    .tile_rst_o(tile_rst_o), .mode_pins(mode_pins), .mode_pins_oe(mode_pins_oe),
    .us_tick(us_tick), .ms_tick(ms_tick), .node_id(node_id), .link_ctl(link_ctl));
  link_remote_model i_far (.ref_clk(ref_clk), .rst(rst), .greeting(link_ctl.greeting),
    .slow(slow), .err_cmd(err_cmd), .credit_issued(credit_issued),
    .credit_held(credit_held), .rx_error(rx_error));
  initial forever #2 ref_clk = ~ref_clk;
  // Oscillator at an eighth of the system clock keeps each level past the pin filter
  initial forever #16 osc_clk_pin = ~osc_clk_pin;
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input logic [32:0] g, input logic [32:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : check
  // Any response with no note waiting is itself a mismatch
  always @(negedge ref_clk) begin
    if (rsp.valid === 1'b1) begin
      if (expq.size() == 0) check({rsp.ack, rsp.rdata}, 33'h1ffffffff);
      else check({rsp.ack, rsp.rdata}, expq.pop_front());
    end
  end
  task automatic cfg(input logic w, rw, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e, input bit due);
    @(posedge ref_clk);
    req <= {1'b1, w, rw, a, d};
    if (due) expq.push_back(e);
  endtask : cfg
  task automatic idle(input int c);
    repeat (c) @(posedge ref_clk) req.valid <= 1'b0;
  endtask : idle
  task automatic wait_for(ref logic s, input logic lvl, input int lim);
    n = 0;
    while (s !== lvl && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    check({32'h0, s}, {32'h0, lvl});
    if (s !== lvl) finish_test();
  endtask : wait_for
  initial begin
    void'($urandom(32'h465c));
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    wait_for(sys_rst_o, 1'b0, 400);
    check({32'h0, n >= 112}, 33'h1);
    cfg(0, 0, 8'h05, 0, {1'b1, 32'h0}, 1);
    cfg(0, 0, 8'h50, 0, {1'b1, 32'h01000000}, 1);
    cfg(0, 0, 8'h51, 0, {1'b1, 32'h00000019}, 1);
    cfg(0, 0, 8'h80, 0, {1'b1, 32'h00000801}, 1);
    cfg(0, 0, 8'h33, 0, {1'b0, 32'h0}, 1);
    idle(3);
    check({30'h0, mode_pins_oe, mode_pins}, 33'h0);
    $display("test reset values done");
    v = $urandom;
    idv = v[15:0];
    cfg(1, 1, 8'h05, v, {1'b1, 32'h0}, 1);
    cfg(0, 0, 8'h05, 0, {1'b1, 16'h0, v[15:0]}, 1);
    v = $urandom;
    cfg(1, 0, 8'h50, v & 32'hfffffffc, 33'h0, 0);
    cfg(0, 0, 8'h50, 0, {1'b1, v & 32'h01030000}, 1);
    idle(3);
    check({17'h0, node_id}, {17'h0, idv});
    check({30'h0, mode_pins_oe, mode_pins}, {30'h0, ~v[24], v[17:16]});
    $display("test id and mode done");
    ef = 7'h19;
    foreach (fv[i]) begin
      v = $urandom;
      if (fv[i] >= 7'h05 && fv[i] <= 7'h64) ef = fv[i];
      cfg(1, 1, 8'h51, {v[31:7], fv[i]}, {ef == fv[i], 32'h0}, 1);
      cfg(0, 0, 8'h51, 0, {1'b1, 25'h0, ef}, 1);
    end
    idle(1);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (us_tick !== 1'b1 && n < 500);
    end
    check({1'b0, n}, {1'b0, 32'h28});
    $display("test frequency done");
    for (int s = 0; s < 2; s++) begin
      v = $urandom;
      slow <= s[0];
      cfg(1, 1, 8'h80, (v & 32'hfe7fffff) | 32'h01000000, {1'b1, 32'h0}, 1);
      idle(1);
      @(negedge ref_clk);
      check({9'h0, link_ctl}, {9'h0, 2'h2, v[21:0]});
      // Old credit from the previous pass must drop before the new answer counts
      wait_for(credit_held, 1'b0, 4);
      wait_for(credit_held, 1'b1, 100);
      cfg(0, 0, 8'h80, 0, {1'b1, 32'h06000000 | (v & 32'h003fffff)}, 1);
      idle(2);
    end
    @(posedge ref_clk) err_cmd <= 1'b1;
    @(posedge ref_clk) err_cmd <= 1'b0;
    idle(2);
    cfg(0, 0, 8'h80, 0, {1'b1, 32'h0e000000 | (v & 32'h003fffff)}, 1);
    cfg(1, 1, 8'h80, (v & 32'hfeffffff) | 32'h00800000, {1'b1, 32'h0}, 1);
    idle(1);
    @(negedge ref_clk);
    check({32'h0, link_ctl.rx_resync}, 33'h1);
    cfg(0, 0, 8'h80, 0, {1'b1, 32'h06000000 | (v & 32'h003fffff)}, 1);
    idle(1);
    $display("test link done");
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      if (k == 0) sleep_done <= 1'b1;
      if (k == 1) clk_src_change <= 1'b1;
      if (k == 2) req <= {1'b1, 1'b1, 1'b1, 8'h50, 32'h00000002};
      @(posedge ref_clk);
      {sleep_done, clk_src_change, req.valid} <= 3'h0;
      wait_for(tile_rst_o, 1'b1, 4);
      check({32'h0, sys_rst_o}, 33'h0);
      wait_for(tile_rst_o, 1'b0, 800);
    end
    $display("test tile reset done");
    // Taken while the frequency is still 5, so a millisecond is about 40000 cycles
    wait_for(ms_tick, 1'b1, 41000);
    for (int k = 0; k < 4; k++) begin
      cfg(1, 1, 8'h51, 32'h0000000a, {1'b1, 32'h0}, 1);
      @(posedge ref_clk);
      if (k < 3) req.valid <= 1'b0;
      if (k == 0) rst_pin_n <= 1'b0;
      if (k == 1) brownout_pin <= 1'b1;
      if (k == 2) wdog_expired <= 1'b1;
      if (k == 3) req <= {1'b1, 1'b1, 1'b1, 8'h50, 32'h00000001};
      @(posedge ref_clk);
      {wdog_expired, req.valid} <= 2'h0;
      wait_for(sys_rst_o, 1'b1, 8);
      @(posedge ref_clk) {rst_pin_n, brownout_pin} <= 2'h2;
      check({32'h0, tile_rst_o}, 33'h1);
      wait_for(sys_rst_o, 1'b0, 400);
      cfg(0, 0, 8'h51, 0, {1'b1, 32'h00000019}, 1);
      idle(2);
    end
    $display("test system reset done");
    idle(4);
    check({32'h0, expq.size() == 0}, 33'h1);
    finish_test();
  end
endmodule : tb_analog_node_reset_link_config
`default_nettype wire

// File: pkg/anrl_consts.svh
// Constants of the analogue node reset, mode and link configuration bank
// Function
// - Pin, brownout or watchdog raise system reset
// - Sleep end or clock change reset tiles
// - System reset covers all; tile only tiles
// - System reset lasts 524,288 oscillator cycles
// - Reset bit 1 starts tile reset, self-clears
// - Reset bit 0 starts system reset, self-clears
// - Reset-bit write gets no response packet
// - Mode pins bits 17:16, tristate bit 24
// - Frequency field 6:0, resets to 25
// - Frequency outside 5..100 ignored and refused
// - Tile delay and ticks derive from frequency
// - Error bit 27 sticky, cleared on read
// - Bits 26 and 25 show credit state
// - Bit 24 clears credit, sends greeting token
// - Bit 23 resynchronises the link receiver
// - Field 21:11 gap inside token, reset 1
// - Field 10:0 gap between tokens, reset 1
// - Node identifier 15:0 read-write, reset zero
`ifndef ANRL_CONSTS_SVH
`define ANRL_CONSTS_SVH
`define ADDR_NODE_ID 8'h05
`define ADDR_RST_MODE 8'h50
`define ADDR_FREQ 8'h51
`define ADDR_LINK 8'h80
`define RM_SYS_BIT 0
`define RM_TILE_BIT 1
`define RM_MODE_LO 16
`define RM_TRI_BIT 24
`define LK_ERR_BIT 27
`define LK_CR_ISS_BIT 26
`define LK_CR_HELD_BIT 25
`define LK_INIT_BIT 24
`define LK_RXRST_BIT 23
`define LK_SYM_LO 11
`define FREQ_RST 7'h19
`define FREQ_MIN 7'h05
`define FREQ_MAX 7'h64
`define GAP_RST 11'h001
`define MODE_RST 2'h0
`define TRI_RST 1'b1
`define SYS_RST_OSC_CYC 524288
`define TILE_RST_US 8'h0a
`define US_PER_MS 10'h3e8
`endif

// File: pkg/anrl_pkg.sv
// Types of the analogue node reset, mode and link configuration bank
package anrl_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic resp_wanted;
    logic [7:0] addr;
    logic [31:0] wdata;
  } cfg_req_t;
  typedef struct packed {
    logic valid;
    logic ack;
    logic [31:0] rdata;
  } cfg_rsp_t;
  typedef struct packed {
    logic greeting;
    logic rx_resync;
    logic [10:0] sym_gap;
    logic [10:0] tok_gap;
  } link_ctl_t;
endpackage : anrl_pkg

// File: rtl/analog_node_reset_link_config.sv
// Reset, mode pin, frequency and link control register bank of the node
`timescale 1ns/100ps
`default_nettype none
`include "anrl_consts.svh"
module analog_node_reset_link_config #(
  parameter int SYS_RST_OSC_CYCLES = `SYS_RST_OSC_CYC
) (
  input wire logic ref_clk, // 250 MHz system clock
  input wire logic rst, // Async reset, high
  input wire anrl_pkg::cfg_req_t req, // Config request, one cycle
  output var anrl_pkg::cfg_rsp_t rsp, // Config response
  input wire logic rst_pin_n, // Reset pin, low
  input wire logic brownout_pin, // Brownout detect pin
  input wire logic osc_clk_pin, // Oscillator clock
  input wire logic wdog_expired, // Watchdog expiry pulse
  input wire logic sleep_done, // Sleep sequence end pulse
  input wire logic clk_src_change, // Clock source change pulse
  input wire logic rx_error, // Link receive error pulse
  input wire logic credit_issued, // Credit given to remote
  input wire logic credit_held, // Credit held locally
  output logic sys_rst_o, // System reset out
  output logic tile_rst_o, // Tile reset out
  output logic [1:0] mode_pins, // Processor mode pins
  output logic mode_pins_oe, // Mode pins drive enable
  output logic us_tick, // Microsecond tick
  output logic ms_tick, // Millisecond tick
  output logic [15:0] node_id, // Node identifier
  output var anrl_pkg::link_ctl_t link_ctl // Link control
);
  import anrl_pkg::*;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Pin synchronisers: bit 0 reset pin, 1 brownout, 2 oscillator
  logic [2:0] s1_ff, s2_ff, s3_ff, filt_ff;
  logic [2:0] nxt_s1, nxt_s2, nxt_s3, nxt_filt;
  logic osc_edge;

  always_comb begin
    nxt_s1 = {osc_clk_pin, brownout_pin, rst_pin_n};
    nxt_s2 = s1_ff;
    nxt_s3 = s2_ff;
    // A level is taken only once the two late stages agree
    nxt_filt = (s2_ff & s3_ff) | (filt_ff & (s2_ff ^ s3_ff));
    osc_edge = nxt_filt[2] & ~filt_ff[2];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_ff <= 3'h1;
      s2_ff <= 3'h1;
      s3_ff <= 3'h1;
      filt_ff <= 3'h1;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      s3_ff <= nxt_s3;
      filt_ff <= nxt_filt;
    end
  end

  // Request decode
  logic wr, rd, hit_id, hit_rm, hit_fq, hit_lk, hit_any;
  logic sw_sys, sw_tile, freq_ok;
  always_comb begin
    wr = req.valid & req.write;
    rd = req.valid & ~req.write;
    hit_id = req.addr == `ADDR_NODE_ID;
    hit_rm = req.addr == `ADDR_RST_MODE;
    hit_fq = req.addr == `ADDR_FREQ;
    hit_lk = req.addr == `ADDR_LINK;
    hit_any = hit_id | hit_rm | hit_fq | hit_lk;
    sw_sys = wr & hit_rm & req.wdata[`RM_SYS_BIT];
    sw_tile = wr & hit_rm & req.wdata[`RM_TILE_BIT];
    freq_ok = req.wdata[6:0] >= `FREQ_MIN && req.wdata[6:0] <= `FREQ_MAX;
  end

  // Reset sequencing and frequency derived ticks
  logic sys_rst_ff, tile_rst_ff, us_tick_ff, ms_tick_ff;
  logic nxt_sys_rst, nxt_tile_rst, nxt_us_tick, nxt_ms_tick;
  logic [19:0] sys_cnt_ff, nxt_sys_cnt;
  logic [7:0] tile_cnt_ff, nxt_tile_cnt;
  logic [6:0] div_ff, nxt_div;
  logic [9:0] ms_cnt_ff, nxt_ms_cnt;
  logic [6:0] freq_ff;

  always_comb begin
    nxt_sys_rst = sys_rst_ff;
    nxt_sys_cnt = sys_cnt_ff;
    nxt_tile_rst = tile_rst_ff;
    nxt_tile_cnt = tile_cnt_ff;
    nxt_div = div_ff;
    nxt_us_tick = 1'b0;
    nxt_ms_cnt = ms_cnt_ff;
    nxt_ms_tick = 1'b0;
    // Any source restarts the count, so the hold runs from the last one
    if (~filt_ff[0] | filt_ff[1] | wdog_expired | sw_sys) begin
      nxt_sys_rst = 1'b1;
      nxt_sys_cnt = 20'h0;
    end else if (sys_rst_ff && osc_edge) begin
      if (sys_cnt_ff == 20'(SYS_RST_OSC_CYCLES - 1)) begin
        nxt_sys_rst = 1'b0;
      end else begin
        nxt_sys_cnt = sys_cnt_ff + 20'h1;
      end
    end
    // Every system reset also resets the tiles
    if (sleep_done | clk_src_change | sw_tile | sys_rst_ff) begin
      nxt_tile_rst = 1'b1;
      nxt_tile_cnt = 8'h0;
    end else if (tile_rst_ff && us_tick_ff) begin
      if (tile_cnt_ff == `TILE_RST_US - 8'h1) begin
        nxt_tile_rst = 1'b0;
      end else begin
        nxt_tile_cnt = tile_cnt_ff + 8'h1;
      end
    end
    // One microsecond is freq_ff oscillator edges
    if (osc_edge) begin
      if (div_ff >= freq_ff - 7'h1) begin
        nxt_div = 7'h0;
        nxt_us_tick = 1'b1;
      end else begin
        nxt_div = div_ff + 7'h1;
      end
    end
    if (us_tick_ff) begin
      if (ms_cnt_ff == `US_PER_MS - 10'h1) begin
        nxt_ms_cnt = 10'h0;
        nxt_ms_tick = 1'b1;
      end else begin
        nxt_ms_cnt = ms_cnt_ff + 10'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sys_rst_ff <= 1'b1;
      sys_cnt_ff <= 20'h0;
      tile_rst_ff <= 1'b1;
      tile_cnt_ff <= 8'h0;
      div_ff <= 7'h0;
      us_tick_ff <= 1'b0;
      ms_cnt_ff <= 10'h0;
      ms_tick_ff <= 1'b0;
    end else begin
      sys_rst_ff <= nxt_sys_rst;
      sys_cnt_ff <= nxt_sys_cnt;
      tile_rst_ff <= nxt_tile_rst;
      tile_cnt_ff <= nxt_tile_cnt;
      div_ff <= nxt_div;
      us_tick_ff <= nxt_us_tick;
      ms_cnt_ff <= nxt_ms_cnt;
      ms_tick_ff <= nxt_ms_tick;
    end
  end

  // Register file and response
  logic [15:0] id_ff, nxt_id;
  logic [1:0] mode_ff, nxt_mode;
  logic tri_ff, nxt_tri, err_ff, nxt_err, init_ff, nxt_init, rxr_ff, nxt_rxr;
  logic oe_ff, nxt_oe;
  logic [6:0] nxt_freq;
  logic [10:0] sym_ff, nxt_sym, tok_ff, nxt_tok;
  logic [31:0] rdata;
  cfg_rsp_t rsp_ff, nxt_rsp;

  always_comb begin
    rdata = 32'h0;
    case (1'b1)
      hit_id: rdata[15:0] = id_ff;
      hit_rm: begin
        rdata[`RM_TRI_BIT] = tri_ff;
        rdata[`RM_MODE_LO +: 2] = mode_ff;
      end
      hit_fq: rdata[6:0] = freq_ff;
      hit_lk: begin
        rdata[`LK_ERR_BIT] = err_ff;
        rdata[`LK_CR_ISS_BIT] = credit_issued;
        rdata[`LK_CR_HELD_BIT] = credit_held;
        rdata[`LK_SYM_LO +: 11] = sym_ff;
        rdata[10:0] = tok_ff;
      end
      default: rdata = 32'h0;
    endcase
  end

  always_comb begin
    nxt_id = id_ff;
    nxt_mode = mode_ff;
    nxt_tri = tri_ff;
    nxt_freq = freq_ff;
    nxt_sym = sym_ff;
    nxt_tok = tok_ff;
    // An error in the read cycle survives the clear
    nxt_err = rx_error | (err_ff & ~(rd & hit_lk));
    nxt_init = wr & hit_lk & req.wdata[`LK_INIT_BIT];
    nxt_rxr = wr & hit_lk & req.wdata[`LK_RXRST_BIT];
    nxt_rsp = '0;
    if (wr && hit_id) nxt_id = req.wdata[15:0];
    if (wr && hit_rm) begin
      nxt_mode = req.wdata[`RM_MODE_LO +: 2];
      nxt_tri = req.wdata[`RM_TRI_BIT];
    end
    if (wr && hit_fq && freq_ok) nxt_freq = req.wdata[6:0];
    if (wr && hit_lk) begin
      nxt_sym = req.wdata[`LK_SYM_LO +: 11];
      nxt_tok = req.wdata[10:0];
    end
    if (rd) begin
      nxt_rsp.valid = 1'b1;
      nxt_rsp.ack = hit_any;
      nxt_rsp.rdata = rdata;
    end else if (wr && req.resp_wanted && !(sw_sys || sw_tile)) begin
      nxt_rsp.valid = 1'b1;
      nxt_rsp.ack = hit_any & ~(hit_fq & ~freq_ok);
    end
    // The system reset returns the whole bank to its defaults
    if (sys_rst_ff) begin
      nxt_id = 16'h0;
      nxt_mode = `MODE_RST;
      nxt_tri = `TRI_RST;
      nxt_freq = `FREQ_RST;
      nxt_sym = `GAP_RST;
      nxt_tok = `GAP_RST;
      nxt_err = 1'b0;
    end
    // Own flop for the enable, so the pin control has no gate after the register
    nxt_oe = ~nxt_tri;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      id_ff <= 16'h0;
      mode_ff <= `MODE_RST;
      tri_ff <= `TRI_RST;
      freq_ff <= `FREQ_RST;
      sym_ff <= `GAP_RST;
      tok_ff <= `GAP_RST;
      err_ff <= 1'b0;
      init_ff <= 1'b0;
      rxr_ff <= 1'b0;
      oe_ff <= ~`TRI_RST;
      rsp_ff <= '0;
    end else begin
      id_ff <= nxt_id;
      mode_ff <= nxt_mode;
      tri_ff <= nxt_tri;
      freq_ff <= nxt_freq;
      sym_ff <= nxt_sym;
      tok_ff <= nxt_tok;
      err_ff <= nxt_err;
      init_ff <= nxt_init;
      rxr_ff <= nxt_rxr;
      oe_ff <= nxt_oe;
      rsp_ff <= nxt_rsp;
    end
  end

  always_comb begin
    rsp = rsp_ff;
    sys_rst_o = sys_rst_ff;
    tile_rst_o = tile_rst_ff;
    mode_pins = mode_ff;
    mode_pins_oe = oe_ff;
    us_tick = us_tick_ff;
    ms_tick = ms_tick_ff;
    node_id = id_ff;
    link_ctl.greeting = init_ff;
    link_ctl.rx_resync = rxr_ff;
    link_ctl.sym_gap = sym_ff;
    link_ctl.tok_gap = tok_ff;
  end

  sequence s_one_pulse(sig);
    sig ##1 !sig;
  endsequence

  property p_pin_rst;
    !filt_ff[0] |=> sys_rst_o;
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset missed");

  property p_tile_ev;
    (sleep_done || clk_src_change) |=> tile_rst_o;
  endproperty
  a_tile_ev: assert property (p_tile_ev) else $error("tile reset missed");

  property p_sys_tile;
    sys_rst_o |=> tile_rst_o;
  endproperty
  a_sys_tile: assert property (p_sys_tile) else $error("tiles left running");

  property p_sys_hold;
    $rose(sys_rst_o) |=> sys_rst_o [*4];
  endproperty
  a_sys_hold: assert property (p_sys_hold) else $error("system reset too short");

  property p_sw_rst;
    (sw_sys |=> sys_rst_o) and (sw_tile |=> tile_rst_o);
  endproperty
  a_sw_rst: assert property (p_sw_rst) else $error("software reset missed");

  property p_no_rsp;
    (sw_sys || sw_tile) |=> !rsp.valid;
  endproperty
  a_no_rsp: assert property (p_no_rsp) else $error("response after reset write");

  property p_freq_bad;
    wr && hit_fq && !freq_ok && req.resp_wanted |=> rsp.valid && !rsp.ack && $stable(freq_ff);
  endproperty
  a_freq_bad: assert property (p_freq_bad) else $error("bad frequency accepted");

  property p_err_set;
    rx_error |=> err_ff;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error flag lost");

  property p_greeting;
    wr && hit_lk && req.wdata[`LK_INIT_BIT] |=> s_one_pulse(link_ctl.greeting);
  endproperty
  a_greeting: assert property (p_greeting) else $error("greeting not one pulse");

  property p_resync;
    wr && hit_lk && req.wdata[`LK_RXRST_BIT] |=> s_one_pulse(link_ctl.rx_resync);
  endproperty
  a_resync: assert property (p_resync) else $error("resync not one pulse");
endmodule : analog_node_reset_link_config
`default_nettype wire
